// ### gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// register offsets on the plain register port
`define GPIO_OFS_VALUE     4'h0
`define GPIO_OFS_DIR       4'h1
`define GPIO_OFS_LATCH     4'h2
`define GPIO_OFS_ANALOG    4'h3
`define GPIO_OFS_PULLUP    4'h4
`define GPIO_OFS_GLOBAL    4'h5

// reset values
`define GPIO_RST_DIR       3'h7
`define GPIO_RST_LATCH     3'h0
`define GPIO_RST_ANALOG    3'h7
`define GPIO_RST_PULLUP    4'hf
`define GPIO_RST_GLOBAL    1'h1

// fixed read values of unimplemented bits
`define GPIO_DIR_PIN3_READ 1'h1

// field positions
`define GPIO_GLOBAL_BIT    0
`define GPIO_INPUT_ONLY    3

`endif

// ### gpio_pkg.sv
package gpio_pkg;
	typedef logic [7:0] gpio_byte_t;

	typedef enum logic [2:0] {
		GPIO_SRC_LATCH = 3'b001,
		GPIO_SRC_MID   = 3'b010,
		GPIO_SRC_HIGH  = 3'b100
	} gpio_src_t;
endpackage

// ### gpio_pin_mux.sv
`timescale 1ns/100ps
// per-pin output selection among peripherals by fixed priority
module gpio_pin_mux
	import gpio_pkg::*;
(
	input  wire logic high_en_i,
	input  wire logic high_val_i,
	input  wire logic mid_en_i,
	input  wire logic mid_val_i,
	input  wire logic dir_in_i,
	input  wire logic latch_i,
	output logic      drive_o,
	output logic      value_o,
	output gpio_src_t src_o
);
	// highest enabled peripheral wins, latch only when none
	assign src_o   = high_en_i ? GPIO_SRC_HIGH : (mid_en_i ? GPIO_SRC_MID : GPIO_SRC_LATCH);
	assign drive_o = high_en_i | mid_en_i | ~dir_in_i;
	assign value_o = high_en_i ? high_val_i : (mid_en_i ? mid_val_i : latch_i);
endmodule

// ### gpio_port.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "gpio_map.svh"
module gpio_port
	import gpio_pkg::*;
#(
	parameter int NUM_OUT = 3
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic [3:0] pin_i,
	output logic [NUM_OUT-1:0] pin_o,
	output logic [NUM_OUT-1:0] pin_oe_o,
	output logic      [3:0] pullup_o,
	output logic [NUM_OUT-1:0] analog_o,
	input  wire logic [NUM_OUT-1:0] per_high_en_i,
	input  wire logic [NUM_OUT-1:0] per_high_val_i,
	input  wire logic [NUM_OUT-1:0] per_mid_en_i,
	input  wire logic [NUM_OUT-1:0] per_mid_val_i,
	output logic      [3:0] digital_in_o
);
	initial begin
		if (NUM_OUT != 3) begin
			$error("gpio_port supports three output pins only");
		end
	end

	// registers
	logic [2:0] dir_r;
	logic [2:0] latch_r;
	logic [2:0] analog_r;
	logic [3:0] pullup_en_r;
	logic       global_off_r;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;

	// address decode
	wire logic sel_value  = addr_i == `GPIO_OFS_VALUE;
	wire logic sel_dir    = addr_i == `GPIO_OFS_DIR;
	wire logic sel_latch  = addr_i == `GPIO_OFS_LATCH;
	wire logic sel_analog = addr_i == `GPIO_OFS_ANALOG;
	wire logic sel_pullup = addr_i == `GPIO_OFS_PULLUP;
	wire logic sel_global = addr_i == `GPIO_OFS_GLOBAL;

	// digital input path, analog pins read zero
	wire logic [3:0] analog_mask = {1'b0, analog_r};
	wire logic [3:0] pin_level   = sync2_r & ~analog_mask;

	// value write: write data stored to latch as is, pin levels masked off
	wire logic [2:0] rmw_base  = pin_level[2:0];
	wire logic [2:0] rmw_value = wdata_i[2:0] | (rmw_base & 3'h0);
	wire logic       latch_we  = wr_i & (sel_value | sel_latch);
	wire logic [2:0] latch_nxt = latch_we ? rmw_value : latch_r;

	// output selection per pin
	wire logic [2:0] mux_drive;
	wire logic [2:0] mux_val;
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_pin
			gpio_pin_mux u_mux (
				.high_en_i  (per_high_en_i[g]),
				.high_val_i (per_high_val_i[g]),
				.mid_en_i   (per_mid_en_i[g]),
				.mid_val_i  (per_mid_val_i[g]),
				.dir_in_i   (dir_r[g]),
				.latch_i    (latch_r[g]),
				.drive_o    (mux_drive[g]),
				.value_o    (mux_val[g]),
				.src_o      ()
			);
		end
	endgenerate

	// pull-up: enable set, global clear, pin not driving
	wire logic [3:0] drive_mask = {1'b0, mux_drive};
	wire logic [3:0] pullup_nxt = pullup_en_r & ~drive_mask
		& {4{~global_off_r}};

	// read data selection
	wire logic [7:0] rd_mux =
		sel_value  ? {4'h0, pin_level} :
		sel_dir    ? {4'h0, `GPIO_DIR_PIN3_READ, dir_r} :
		sel_latch  ? {5'h00, latch_r} :
		sel_analog ? {5'h00, analog_r} :
		sel_pullup ? {4'h0, pullup_en_r} :
		sel_global ? {7'h00, global_off_r} : 8'h00;

	// input synchroniser
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	// control registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dir_r        <= `GPIO_RST_DIR;
			latch_r      <= `GPIO_RST_LATCH;
			analog_r     <= `GPIO_RST_ANALOG;
			pullup_en_r  <= `GPIO_RST_PULLUP;
			global_off_r <= `GPIO_RST_GLOBAL;
		end else begin
			latch_r <= latch_nxt;
			if (wr_i && sel_dir) begin
				dir_r <= wdata_i[2:0];
			end
			if (wr_i && sel_analog) begin
				analog_r <= wdata_i[2:0];
			end
			if (wr_i && sel_pullup) begin
				pullup_en_r <= wdata_i[3:0];
			end
			if (wr_i && sel_global) begin
				global_off_r <= wdata_i[`GPIO_GLOBAL_BIT];
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o      <= 8'h00;
			pin_o        <= 3'h0;
			pin_oe_o     <= 3'h0;
			pullup_o     <= 4'h0;
			analog_o     <= 3'h0;
			digital_in_o <= 4'h0;
		end else begin
			rdata_o      <= rd_i ? rd_mux : 8'h00;
			pin_o        <= mux_val;
			pin_oe_o     <= mux_drive;
			pullup_o     <= pullup_nxt;
			analog_o     <= analog_r;
			digital_in_o <= pin_level;
		end
	end
endmodule

// ### gpio_pin_world.sv
`timescale 1ns/100ps
module gpio_pin_world (
	input  wire logic       clk_i,
	input  wire logic [2:0] oe_i,
	input  wire logic [2:0] val_i,
	input  wire logic [3:0] pu_i,
	input  wire logic [3:0] ext_i,
	input  wire logic [3:0] ext_en_i,
	output logic      [3:0] lvl_o
);
	logic       f_r = 1'b0;
	wire  [3:0] oe  = {1'b0, oe_i};
	wire  [3:0] val = {1'b0, val_i};
	// an undriven, unpulled pin wanders
	always_ff @(posedge clk_i) f_r <= ~f_r;
	// port driver, then outside source, then pull-up
	assign lvl_o = (oe & val) | (~oe & ext_en_i & ext_i) | (~oe & ~ext_en_i & (pu_i | {4{f_r}}));
endmodule

// ### gpio_port_chk_sva.sv
`timescale 1ns/100ps
module gpio_port_chk (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe_o,
	input wire logic [3:0] pullup_o,
	input wire logic [2:0] analog_o,
	input wire logic [2:0] per_high_en_i,
	input wire logic [2:0] per_high_val_i,
	input wire logic [2:0] per_mid_en_i,
	input wire logic [3:0] digital_in_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// latch write, idle cycle, latch read
	sequence s_wr_rd;
		wr_i && addr_i == 4'h2 ##1 !wr_i ##1 rd_i && addr_i == 4'h2;
	endsequence
	a_rd_idle: assert property (
		!$past(rd_i) || $past(addr_i) > 4'h5 |-> rdata_o == 8'h00) else $error("rdata not zero");
	a_dir_fixed: assert property (
		$past(rd_i) && $past(addr_i) == 4'h1 |-> rdata_o[7:3] == 5'h01) else $error("dir read");
	a_latch_back: assert property (
		s_wr_rd |=> rdata_o[2:0] == $past(wdata_i[2:0], 3)) else $error("latch readback");
	a_reset_state: assert property (
		$rose(resetn_i) |=> pullup_o == 4'h0 && analog_o == 3'h7 && pin_oe_o == 3'h0)
		else $error("reset state");
	a_pull_drive: assert property (
		(pullup_o[2:0] & pin_oe_o) == 3'h0) else $error("pull-up on driven pin");
	a_ana_zero: assert property (
		(digital_in_o[2:0] & analog_o & $past(analog_o)) == 3'h0) else $error("analog reads one");
	a_peri_owns: assert property (
		$past(resetn_i) |-> (pin_oe_o & $past(per_high_en_i | per_mid_en_i))
		== $past(per_high_en_i | per_mid_en_i)) else $error("peripheral not driving");
	a_high_wins: assert property (
		$past(resetn_i) |-> (pin_o & $past(per_high_en_i)) == $past(per_high_val_i & per_high_en_i))
		else $error("high priority value");
endmodule
bind gpio_port gpio_port_chk gpio_port_chk_i (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .pin_o, .pin_oe_o, .pullup_o, .analog_o, .per_high_en_i, .per_high_val_i,
	.per_mid_en_i, .digital_in_o);

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic       clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0, ext = 4'h8, ext_en = 4'h8, pin_i, pullup_o, dig;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic [2:0] pin_o, pin_oe_o, analog_o, he = 3'h0, hv = 3'h0, me = 3'h0, mv = 3'h0;
	int         miscompares = 0, num_checks = 0, cyc = 0;
	always #12.5 clk_i = ~clk_i;
	gpio_port gpio_port_i (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i,
		.pin_o, .pin_oe_o, .pullup_o, .analog_o, .per_high_en_i(he), .per_high_val_i(hv),
		.per_mid_en_i(me), .per_mid_val_i(mv), .digital_in_o(dig));
	gpio_pin_world gpio_pin_world_i (.clk_i, .oe_i(pin_oe_o), .val_i(pin_o), .pu_i(pullup_o),
		.ext_i(ext), .ext_en_i(ext_en), .lvl_o(pin_i));
	task end_sim;
		if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(logic [7:0] got, logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge clk_i) wr_i <= 1'b0;
	endtask
	task rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_i) rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(1, 8'h0f);
		rd(3, 8'h07);
		rd(4, 8'h0f);
		rd(5, 8'h01);
		rd(9, 8'h00);
		wr(3, 8'hf8);
		wr(1, 8'hf0);
		wr(0, 8'hfd);
		rd(2, 8'h05);
		chk(pin_o, 5);
		wr(2, 8'h02);
		rd(2, 8'h02);
		chk(pin_o, 2);
		wr(3, 8'h01);
		rd(0, 8'h0a);
		chk(pin_oe_o, 7);
		wr(1, 8'h07);
		{ext, ext_en} <= 8'h5f;
		wr(3, 8'h00);
		rd(0, 8'h05);
		wr(3, 8'h07);
		rd(0, 8'h00);
		chk(dig, 0);
		wr(5, 8'h00);
		ext_en <= 4'h0;
		rd(5, 8'h00);
		chk(pullup_o, 15);
		wr(1, 8'h00);
		rd(1, 8'h08);
		chk(pullup_o, 8);
		{he, hv, me} <= 9'o113;
		wr(1, 8'h07);
		wr(3, 8'h00);
		rd(0, 8'h0d);
		chk(pin_o, 1);
		chk(pin_oe_o, 3);
		end_sim;
	end
endmodule
